// file: charge_setpoint_map.svh
// Register offsets, field positions and fixed values of the charge setpoint bank
`ifndef CHARGE_SETPOINT_MAP_SVH
`define CHARGE_SETPOINT_MAP_SVH
`define CC_LOW_ADDR 8'h02
`define CC_HIGH_ADDR 8'h03
`define CV_LOW_ADDR 8'h04
`define CV_HIGH_ADDR 8'h05
`define CC_HIGH_RSVD_MASK 8'hE0
`define CV_HIGH_RSVD_MASK 8'h80
`define CC_CODE_ZERO 7'h00
`define CV_CODE_ZERO 12'h000
`define CC_STEP_SHIFT_5M 7
`define CC_STEP_SHIFT_10M 6
`define CV_STEP_SHIFT 3
`define CV_MIN_MV 16'h0400
`define CV_MAX_MV 16'h59D8
`define CV_1CELL_MV 16'h1068
`define CV_2CELL_MV 16'h20D0
`define CV_3CELL_MV 16'h3138
`define CV_4CELL_MV 16'h41A0
`define CV_5CELL_MV 16'h5208
`define PRECHG_CLAMP_MA 16'h0180
`define FAST_1CELL_CLAMP_MA 16'h07D0
`define ONE_CELL_PRE_MV 16'h0BB8
`define ONE_CELL_LIN_MV 16'h0E10
`define BYTE_ZERO 8'h00
`endif

// file: charge_setpoint_pkg.sv
// Types shared by the charge setpoint bank
package charge_setpoint_pkg;
  typedef enum logic [2:0] {
    CELLS_1 = 3'b001,
    CELLS_2 = 3'b010,
    CELLS_3 = 3'b011,
    CELLS_4 = 3'b100,
    CELLS_5 = 3'b101
  } cell_count_type;
  typedef enum logic [1:0] {
    CHG_IDLE = 2'b00,
    CHG_ACTIVE = 2'b01
  } charge_state_type;
endpackage : charge_setpoint_pkg

// file: charge_setpoint_registers.sv
// Charge current and charge voltage setpoint registers with range checks and pre-charge clamps
`timescale 1ns/1ns
`include "charge_setpoint_map.svh"

// Operation
// - Upper current byte bits 4..0 weigh 8192, 4096, 2048, 1024, 512 mA.
// - Lower current byte bits 7 and 6 weigh 256 and 128 mA.
// - A one in reserved top bits of upper bytes makes the write invalid.
// - Lower current byte bits 5..0 are ignored and read zero.
// - Two to five cells in linear pre-charge: regulate at minimum system voltage, 384 mA.
// - One cell: pre-charge below 3 V with current held to 384 mA.
// - One cell: switch linear below 3.6 V; fast charge clamped 2 A there.
// - Voltage setpoints span 1.024 V to 23.000 V in 8 mV steps.
// - Voltage writes outside that span are dropped, old setpoint kept.
// - Power-on voltage comes from cell count: 4200 to 21000 mV.
// - With power good, a current write starts charge at stored voltage.
// - Zero voltage write keeps voltage and clears current, stopping charge.
// - Upper voltage byte bits 6..0 weigh 16384 down to 256 mV.
// - Lower voltage byte bits 7 and 6 weigh 128 and 64 mV.
// - Current clears on battery or adapter removal, register reset, zero voltage, watchdog.
// - Higher sense resistor halves current weights: 64 mA step, 8.128 A top.
module charge_setpoint_registers (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [2:0] cell_count_i,
  input wire logic battery_present_i,
  input wire logic adapter_valid_i,
  input wire logic charger_power_good_i,
  input wire logic reg_reset_i,
  input wire logic watchdog_expire_i,
  input wire logic sense_10mohm_i,
  input wire logic linear_precharge_enable_i,
  input wire logic [15:0] vbat_mv_i,
  input wire logic [15:0] vsys_min_mv_i,
  output logic [7:0] rdata_o,
  output logic invalid_write_o,
  output logic [15:0] charge_voltage_mv_o,
  output logic [15:0] current_limit_ma_o,
  output logic charging_o,
  output logic battery_switch_linear_o,
  output logic regulate_at_vsys_min_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [6:0] cc_code;
  logic [11:0] cv_code;
  logic [7:0] cc_low_pend;
  logic [7:0] cv_low_pend;
  charge_setpoint_pkg::charge_state_type chg_state;

  logic wr_cc_low;
  logic wr_cc_high;
  logic wr_cv_low;
  logic wr_cv_high;
  logic cc_bad;
  logic cv_bad;
  logic [11:0] next_cv_code;
  logic [15:0] next_cv_mv;
  logic cv_zero;
  logic cv_in_range;
  logic cc_clear;
  logic [11:0] default_cv_code;
  logic [15:0] setpoint_ma;
  logic [15:0] clamp_ma;
  logic one_cell;
  logic linear_region;

  assign wr_cc_low = wr_stb_i && (addr_i == `CC_LOW_ADDR);
  assign wr_cc_high = wr_stb_i && (addr_i == `CC_HIGH_ADDR);
  assign wr_cv_low = wr_stb_i && (addr_i == `CV_LOW_ADDR);
  assign wr_cv_high = wr_stb_i && (addr_i == `CV_HIGH_ADDR);
  assign cc_bad = (wdata_i & `CC_HIGH_RSVD_MASK) != `BYTE_ZERO;
  assign cv_bad = (wdata_i & `CV_HIGH_RSVD_MASK) != `BYTE_ZERO;

  // Voltage word assembled from the pending low byte and the arriving high byte
  assign next_cv_code = {wdata_i[6:0], cv_low_pend[7:3]};
  assign next_cv_mv = {1'b0, next_cv_code, 3'b000};
  assign cv_zero = next_cv_code == `CV_CODE_ZERO;
  assign cv_in_range = (next_cv_mv >= `CV_MIN_MV) && (next_cv_mv <= `CV_MAX_MV);

  // Zero voltage write is handled before the range check, so it never looks invalid
  assign cc_clear = !battery_present_i || !adapter_valid_i || reg_reset_i || watchdog_expire_i
                    || (wr_cv_high && !cv_bad && cv_zero);

  always_comb begin
    case (cell_count_i)
      charge_setpoint_pkg::CELLS_1: default_cv_code = 12'(`CV_1CELL_MV >> `CV_STEP_SHIFT);
      charge_setpoint_pkg::CELLS_2: default_cv_code = 12'(`CV_2CELL_MV >> `CV_STEP_SHIFT);
      charge_setpoint_pkg::CELLS_3: default_cv_code = 12'(`CV_3CELL_MV >> `CV_STEP_SHIFT);
      charge_setpoint_pkg::CELLS_4: default_cv_code = 12'(`CV_4CELL_MV >> `CV_STEP_SHIFT);
      charge_setpoint_pkg::CELLS_5: default_cv_code = 12'(`CV_5CELL_MV >> `CV_STEP_SHIFT);
      default: default_cv_code = 12'(`CV_1CELL_MV >> `CV_STEP_SHIFT);
    endcase
  end

  // ----------------------------------------------------------------
  // Pending low bytes
  // ----------------------------------------------------------------
  // Low bytes wait here so a half-written word never reaches the loops
  always_ff @(posedge mclk_i) begin
    if (srst_i || reg_reset_i) begin
      cc_low_pend <= `BYTE_ZERO;
      cv_low_pend <= `BYTE_ZERO;
    end else begin
      if (wr_cc_low) begin
        cc_low_pend <= {wdata_i[7:6], 6'b00_0000};
      end
      if (wr_cv_low) begin
        cv_low_pend <= {wdata_i[7:3], 3'b000};
      end
    end
  end

  // ----------------------------------------------------------------
  // Charge current setpoint
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cc_code <= `CC_CODE_ZERO;
    end else if (cc_clear) begin
      cc_code <= `CC_CODE_ZERO;
    end else if (wr_cc_high && !cc_bad) begin
      cc_code <= {wdata_i[4:0], cc_low_pend[7:6]};
    end
  end

  // ----------------------------------------------------------------
  // Charge voltage setpoint
  // ----------------------------------------------------------------
  // Synchronous reset, so the strap may be sampled while reset is held
  always_ff @(posedge mclk_i) begin
    if (srst_i || reg_reset_i) begin
      cv_code <= default_cv_code;
    end else if (wr_cv_high && !cv_bad && !cv_zero && cv_in_range) begin
      cv_code <= next_cv_code;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      invalid_write_o <= 1'b0;
    end else begin
      invalid_write_o <= (wr_cc_high && cc_bad) || (wr_cv_high && cv_bad);
    end
  end

  // ----------------------------------------------------------------
  // Charge start
  // ----------------------------------------------------------------
  // Voltage order is the host's concern; charge uses whatever voltage is stored
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      chg_state <= charge_setpoint_pkg::CHG_IDLE;
    end else begin
      case (chg_state)
        charge_setpoint_pkg::CHG_IDLE: begin
          if (charger_power_good_i && !cc_clear && wr_cc_high && !cc_bad
              && (wdata_i[4:0] != 5'b0_0000 || cc_low_pend[7:6] != 2'b00)) begin
            chg_state <= charge_setpoint_pkg::CHG_ACTIVE;
          end
        end
        charge_setpoint_pkg::CHG_ACTIVE: begin
          if (cc_clear || !charger_power_good_i || cc_code == `CC_CODE_ZERO) begin
            chg_state <= charge_setpoint_pkg::CHG_IDLE;
          end
        end
        default: chg_state <= charge_setpoint_pkg::CHG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Current weighting and pre-charge clamps
  // ----------------------------------------------------------------
  assign setpoint_ma = sense_10mohm_i ? {3'b000, cc_code, 6'b00_0000}
                                      : {2'b00, cc_code, 7'b000_0000};
  assign one_cell = cell_count_i == charge_setpoint_pkg::CELLS_1;
  assign linear_region = linear_precharge_enable_i
                         && (one_cell ? (vbat_mv_i < `ONE_CELL_LIN_MV) : (vbat_mv_i < vsys_min_mv_i));

  always_comb begin
    clamp_ma = setpoint_ma;
    if (linear_region) begin
      if (one_cell && vbat_mv_i >= `ONE_CELL_PRE_MV) begin
        if (setpoint_ma > `FAST_1CELL_CLAMP_MA) begin
          clamp_ma = `FAST_1CELL_CLAMP_MA;
        end
      end else if (setpoint_ma > `PRECHG_CLAMP_MA) begin
        clamp_ma = `PRECHG_CLAMP_MA;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      current_limit_ma_o <= 16'h0000;
      charging_o <= 1'b0;
      battery_switch_linear_o <= 1'b0;
      regulate_at_vsys_min_o <= 1'b0;
      charge_voltage_mv_o <= 16'h0000;
    end else begin
      current_limit_ma_o <= (chg_state == charge_setpoint_pkg::CHG_ACTIVE) ? clamp_ma : 16'h0000;
      charging_o <= chg_state == charge_setpoint_pkg::CHG_ACTIVE;
      battery_switch_linear_o <= linear_region;
      regulate_at_vsys_min_o <= linear_region && !one_cell;
      charge_voltage_mv_o <= {1'b0, cv_code, 3'b000};
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= `BYTE_ZERO;
    end else if (rd_stb_i) begin
      if (addr_i == `CC_LOW_ADDR) begin
        rdata_o <= {cc_code[1:0], 6'b00_0000};
      end else if (addr_i == `CC_HIGH_ADDR) begin
        rdata_o <= {3'b000, cc_code[6:2]};
      end else if (addr_i == `CV_LOW_ADDR) begin
        rdata_o <= {cv_code[4:0], 3'b000};
      end else if (addr_i == `CV_HIGH_ADDR) begin
        rdata_o <= {1'b0, cv_code[11:5]};
      end else begin
        rdata_o <= `BYTE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_zero_cv_write;
    wr_cv_high && !cv_bad && cv_zero;
  endsequence
  sequence s_rd_cc_low;
    rd_stb_i && addr_i == `CC_LOW_ADDR;
  endsequence

  property p_rsvd_cc;
    wr_cc_high && cc_bad && !cc_clear |=> $stable(cc_code) && invalid_write_o;
  endproperty
  a_rsvd_cc: assert property (p_rsvd_cc) else $error("reserved current bit write not refused");

  property p_rsvd_cv;
    wr_cv_high && cv_bad && !reg_reset_i |=> $stable(cv_code) && invalid_write_o;
  endproperty
  a_rsvd_cv: assert property (p_rsvd_cv) else $error("reserved voltage bit write not refused");

  property p_low_ignored;
    s_rd_cc_low |=> rdata_o[5:0] == 6'b00_0000;
  endproperty
  a_low_ignored: assert property (p_low_ignored) else $error("ignored current bits read back");

  property p_range;
    wr_cv_high && !cv_bad && !cv_zero && !cv_in_range && !reg_reset_i |=> $stable(cv_code);
  endproperty
  a_range: assert property (p_range) else $error("out of range voltage accepted");

  property p_zero_cv;
    s_zero_cv_write ##0 !reg_reset_i |=> cc_code == `CC_CODE_ZERO && $stable(cv_code) ##1 !charging_o;
  endproperty
  a_zero_cv: assert property (p_zero_cv) else $error("zero voltage write did not stop charge");

  property p_clear;
    !battery_present_i || !adapter_valid_i || watchdog_expire_i |=> cc_code == `CC_CODE_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("current not cleared on removal or watchdog");

  property p_low_pending;
    wr_cc_low && !cc_clear |=> $stable(cc_code);
  endproperty
  a_low_pending: assert property (p_low_pending) else $error("low byte alone changed setpoint");

  property p_start;
    charger_power_good_i && !cc_clear && wr_cc_high && !cc_bad && wdata_i[4:0] != 5'b0_0000
      |=> ##1 charging_o;
  endproperty
  a_start: assert property (p_start) else $error("charge did not start on current write");

  property p_clamp;
    charging_o && battery_switch_linear_o && !one_cell |-> current_limit_ma_o <= `PRECHG_CLAMP_MA;
  endproperty
  a_clamp: assert property (p_clamp) else $error("pre-charge clamp exceeded");

endmodule : charge_setpoint_registers

// file: charge_setpoint_registers_tb.sv
// Self-checking bench of the charge setpoint bank
`timescale 1ns/1ns
module charge_setpoint_registers_tb;
  logic mclk_i = 1'b0, srst_i = 1'b1, battery_present_i = 1'b1, adapter_valid_i = 1'b1;
  logic charger_power_good_i = 1'b1, reg_reset_i = 1'b0, watchdog_expire_i = 1'b0, sense_10mohm_i = 1'b0;
  logic linear_precharge_enable_i = 1'b1, wr_stb_i, rd_stb_i, invalid_write_o, charging_o;
  logic battery_switch_linear_o, regulate_at_vsys_min_o;
  logic [2:0] cell_count_i = 3'h1;
  logic [7:0] addr_i, wdata_i, rdata_o, d;
  logic [15:0] vbat_mv_i = 16'h4E20, vsys_min_mv_i = 16'h0E10, charge_voltage_mv_o, current_limit_ma_o, w, ev, ei;
  int err_count = 0, n_tests = 0;
  always #10 mclk_i = ~mclk_i;
  setpoint_host host_u (.clk_i(mclk_i), .rdata_i(rdata_o), .wr_stb_o(wr_stb_i), .rd_stb_o(rd_stb_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  charge_setpoint_registers dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .cell_count_i(cell_count_i), .battery_present_i(battery_present_i),
    .adapter_valid_i(adapter_valid_i), .charger_power_good_i(charger_power_good_i), .reg_reset_i(reg_reset_i),
    .watchdog_expire_i(watchdog_expire_i), .sense_10mohm_i(sense_10mohm_i),
    .linear_precharge_enable_i(linear_precharge_enable_i), .vbat_mv_i(vbat_mv_i), .vsys_min_mv_i(vsys_min_mv_i),
    .rdata_o(rdata_o), .invalid_write_o(invalid_write_o), .charge_voltage_mv_o(charge_voltage_mv_o),
    .current_limit_ma_o(current_limit_ma_o), .charging_o(charging_o),
    .battery_switch_linear_o(battery_switch_linear_o), .regulate_at_vsys_min_o(regulate_at_vsys_min_o));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [15:0] cc_ma(input logic [15:0] cw, input logic s10);
    cc_ma = {9'h000, cw[12:6]} << (s10 ? 6 : 7);
  endfunction : cc_ma
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic [2:0] c);
    @(posedge mclk_i);
    cell_count_i <= c;
    srst_i <= 1'b1;
    repeat (7) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : do_reset
  // Write, then check the pulse cycle and the settled outputs; charging follows a nonzero current
  task automatic wchk(input logic [7:0] a, input logic [15:0] wd, input logic inv, input logic [15:0] v,
    input logic [15:0] i);
    host_u.wr16(a, wd);
    @(negedge mclk_i);
    chk(invalid_write_o, inv);
    @(negedge mclk_i);
    chk(invalid_write_o, 1'b0);
    chk(charge_voltage_mv_o, v);
    chk(current_limit_ma_o, i);
    // A zero current ends charge one cycle after the current itself drops
    @(negedge mclk_i);
    chk(charging_o, i != 16'h0000);
  endtask : wchk
  task automatic cl(input logic [15:0] v, input logic [15:0] i, input logic lin, input logic rg);
    @(posedge mclk_i);
    vbat_mv_i <= v;
    repeat (3) @(negedge mclk_i);
    chk(current_limit_ma_o, i);
    chk(battery_switch_linear_o, lin);
    chk(regulate_at_vsys_min_o, rg);
  endtask : cl
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (16'h4E20) @(posedge mclk_i);
    err_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(99));
    for (int c = 1; c <= 5; c++) begin
      do_reset(c[2:0]);
      chk(charge_voltage_mv_o, 16'h1068 * c[15:0]);
      chk(current_limit_ma_o, 16'h0000);
      host_u.rd8(8'h03, d);
      chk(d, 8'h00);
    end
    do_reset(3'h1);
    ev = 16'h1068;
    for (int k = 0; k < 14; k++) begin
      w = (k == 0) ? 16'h1FFF : 16'h1FFF & 16'($urandom);
      @(posedge mclk_i);
      sense_10mohm_i <= k[0];
      wchk(8'h02, w, 1'b0, ev, cc_ma(w, k[0]));
      host_u.rd8(8'h03, d);
      chk(d, w[15:8]);
      host_u.rd8(8'h02, d);
      chk(d, {w[7:6], 6'h00});
    end
    @(posedge mclk_i);
    sense_10mohm_i <= 1'b0;
    charger_power_good_i <= 1'b0;
    wchk(8'h02, 16'h0040, 1'b0, ev, 16'h0000);
    @(posedge mclk_i);
    charger_power_good_i <= 1'b1;
    ei = 16'h0080;
    wchk(8'h02, 16'h0040, 1'b0, ev, ei);
    for (int b = 13; b < 16; b++) begin
      wchk(8'h02, 16'h0FC0 | (16'h0001 << b), 1'b1, ev, ei);
    end
    wchk(8'h04, 16'h9068, 1'b1, ev, ei);
    for (int k = 0; k < 16; k++) begin
      case (k)
        0: w = 16'h0400;
        1: w = 16'h03F8;
        2: w = 16'h59D8;
        3: w = 16'h59E0;
        4: w = 16'h7FF8;
        15: w = 16'h0000;
        default: w = 16'h7FF8 & 16'($urandom);
      endcase
      if (w >= 16'h0400 && w <= 16'h59D8) ev = w;
      if (w == 16'h0000) ei = 16'h0000;
      wchk(8'h04, w | (16'h0007 & 16'($urandom)), 1'b0, ev, ei);
      host_u.rd8(8'h05, d);
      chk(d, ev[15:8]);
      host_u.rd8(8'h04, d);
      chk(d, ev[7:0]);
    end
    for (int k = 0; k < 4; k++) begin
      wchk(8'h02, 16'h0080, 1'b0, ev, 16'h0100);
      @(posedge mclk_i);
      battery_present_i <= (k != 0);
      adapter_valid_i <= (k != 1);
      reg_reset_i <= (k == 2);
      watchdog_expire_i <= (k == 3);
      @(posedge mclk_i);
      battery_present_i <= 1'b1;
      adapter_valid_i <= 1'b1;
      reg_reset_i <= 1'b0;
      watchdog_expire_i <= 1'b0;
      if (k == 2) ev = 16'h1068;
      repeat (2) @(negedge mclk_i);
      chk(current_limit_ma_o, 16'h0000);
      chk(charging_o, 1'b0);
      chk(charge_voltage_mv_o, ev);
      host_u.rd8(8'h03, d);
      chk(d, 8'h00);
    end
    do_reset(3'h1);
    wchk(8'h04, 16'h1068, 1'b0, 16'h1068, 16'h0000);
    wchk(8'h02, 16'h1000, 1'b0, 16'h1068, 16'h2000);
    cl(16'h07D0, 16'h0180, 1'b1, 1'b0);
    cl(16'h0CE4, 16'h07D0, 1'b1, 1'b0);
    cl(16'h0E74, 16'h2000, 1'b0, 1'b0);
    @(posedge mclk_i);
    vbat_mv_i <= 16'h4E20;
    vsys_min_mv_i <= 16'h1770;
    do_reset(3'h2);
    wchk(8'h04, 16'h20D0, 1'b0, 16'h20D0, 16'h0000);
    wchk(8'h02, 16'h1000, 1'b0, 16'h20D0, 16'h2000);
    cl(16'h1388, 16'h0180, 1'b1, 1'b1);
    @(posedge mclk_i);
    linear_precharge_enable_i <= 1'b0;
    cl(16'h1388, 16'h2000, 1'b0, 1'b0);
    @(posedge mclk_i);
    linear_precharge_enable_i <= 1'b1;
    cl(16'h1B58, 16'h2000, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : charge_setpoint_registers_tb

// file: setpoint_host.sv
// Host model that writes and reads the setpoint bank through its byte strobe port
`timescale 1ns/1ns
module setpoint_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // ----------------
  // Bus transfers
  // ----------------
  initial begin
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One 16-bit command: low byte stages, high byte follows on the next cycle
  task automatic wr16(input logic [7:0] lo_addr, input logic [15:0] word);
    @(posedge clk_i);
    wr_stb_o <= 1'b1;
    addr_o <= lo_addr;
    wdata_o <= word[7:0];
    @(posedge clk_i);
    addr_o <= lo_addr + 8'h01;
    wdata_o <= word[15:8];
    @(posedge clk_i);
    wr_stb_o <= 1'b0;
    // Released lines change, so a stale value can never be mistaken for a request
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask : wr16
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_stb_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_stb_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd8
endmodule : setpoint_host
